// [hw/trut_pkg.sv]
// trut_pkg: constants and carriers for the three rollover up timers
// assumes a plain register port with byte addresses on a 32-bit word map
package trut_pkg;
  localparam int TRUT_NUM_TIMERS = 3;
  localparam int TRUT_ADDR_W = 32;
  localparam int TRUT_DATA_W = 32;
  // register byte addresses
  localparam logic [31:0] TRUT_BASE_ADDR = 32'h5002_0000;
  localparam logic [31:0] TRUT_TIMER_ZERO_START_COUNT_ADDR = 32'h5002_0000;
  localparam logic [31:0] TRUT_TIMER_ZERO_CONTROL_ADDR = 32'h5002_0004;
  localparam logic [31:0] TRUT_TIMER_ONE_START_COUNT_ADDR = 32'h5002_0008;
  localparam logic [31:0] TRUT_TIMER_ONE_CONTROL_ADDR = 32'h5002_000C;
  localparam logic [31:0] TRUT_TIMER_TWO_START_COUNT_ADDR = 32'h5002_0010;
  localparam logic [31:0] TRUT_TIMER_TWO_CONTROL_ADDR = 32'h5002_0014;
  // interrupt registers placed in a free window of the same page
  localparam logic [31:0] TRUT_IRQ_STATUS_ADDR = 32'h5002_0060;
  localparam logic [31:0] TRUT_IRQ_MASK_ADDR = 32'h5002_0064;
  // timer n start count at base + 8*n, control at base + 8*n + 4
  localparam logic [31:0] TRUT_TIMER_STRIDE = 32'h0000_0008;
  localparam logic [31:0] TRUT_CONTROL_OFFSET = 32'h0000_0004;
  // field layout and reset values
  localparam int TRUT_RUN_BIT = 0;
  localparam logic [31:0] TRUT_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] TRUT_COUNT_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] TRUT_COUNT_WRAP = 32'h0000_0000;
  localparam logic [31:0] TRUT_COUNT_STEP = 32'h0000_0001;
  localparam logic TRUT_RUN_RESET = 1'b0;
  localparam logic [2:0] TRUT_IRQ_RESET = 3'h0;
  localparam logic [31:0] TRUT_READ_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } trut_bus_req_t;

  typedef enum logic [1:0] {
    TRUT_REG_START_COUNT = 2'h1,
    TRUT_REG_CONTROL = 2'h2
  } trut_reg_kind_t;
endpackage

// [hw/trut_timers.sv]
// trut_timers: three 32-bit up timers with rollover interrupt and register port
// assumes one 100 MHz clock, async active-high reset, single-cycle register strobes
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module trut_timers
  import trut_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [trut_pkg::TRUT_ADDR_W-1:0] addr_in,
  input wire logic [trut_pkg::TRUT_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [trut_pkg::TRUT_DATA_W-1:0] rdata_out,
  output logic [2:0] run_out,
  output logic [2:0] wrap_out,
  output logic irq_out
);
  import trut_pkg::*;

  trut_bus_req_t req;
  logic [31:0] count [TRUT_NUM_TIMERS];
  logic [2:0] run_control_bit;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] load_hit;
  logic [2:0] ctrl_hit;
  logic [2:0] wrap_evt;
  logic status_hit;
  logic mask_hit;

  // which timer register an address names, if any
  function automatic trut_reg_kind_t trut_decode(input logic [31:0] a, input int idx);
    logic [31:0] base;
    base = TRUT_BASE_ADDR + (TRUT_TIMER_STRIDE * 32'(idx));
    if (a == base)
    begin
      return TRUT_REG_START_COUNT;
    end
    else if (a == base + TRUT_CONTROL_OFFSET)
    begin
      return TRUT_REG_CONTROL;
    end
    return trut_reg_kind_t'(2'h0);
  endfunction

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign status_hit = (req.addr == TRUT_IRQ_STATUS_ADDR);
  assign mask_hit = (req.addr == TRUT_IRQ_MASK_ADDR);

  always_comb
  begin
    for (int i = 0; i < TRUT_NUM_TIMERS; i++)
    begin
      load_hit[i] = req.wr && (trut_decode(req.addr, i) == TRUT_REG_START_COUNT);
      ctrl_hit[i] = req.wr && (trut_decode(req.addr, i) == TRUT_REG_CONTROL);
      wrap_evt[i] = run_control_bit[i] && !load_hit[i] && (count[i] == TRUT_COUNT_MAX);
    end
  end

  // counters
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < TRUT_NUM_TIMERS; i++)
      begin
        count[i] <= TRUT_COUNT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < TRUT_NUM_TIMERS; i++)
      begin
        if (load_hit[i])
        begin
          count[i] <= req.wdata;
        end
        else if (wrap_evt[i])
        begin
          count[i] <= TRUT_COUNT_WRAP;
        end
        else if (run_control_bit[i])
        begin
          count[i] <= count[i] + TRUT_COUNT_STEP;
        end
      end
    end
  end

  // run control bits
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      run_control_bit <= {3{TRUT_RUN_RESET}};
    end
    else
    begin
      for (int i = 0; i < TRUT_NUM_TIMERS; i++)
      begin
        if (ctrl_hit[i])
        begin
          run_control_bit[i] <= req.wdata[TRUT_RUN_BIT];
        end
      end
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_status <= TRUT_IRQ_RESET;
    end
    else
    begin
      irq_status <= (irq_status & ~((req.wr && status_hit) ? req.wdata[2:0] : 3'h0))
        | wrap_evt;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_mask <= TRUT_IRQ_RESET;
    end
    else if (req.wr && mask_hit)
    begin
      irq_mask <= req.wdata[2:0];
    end
  end

  // read data in the cycle after the strobe only
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rdata_out <= TRUT_READ_UNMAPPED;
    end
    else
    begin
      rdata_out <= TRUT_READ_UNMAPPED;
      if (req.rd)
      begin
        if (status_hit)
        begin
          rdata_out <= {29'h0, irq_status};
        end
        else if (mask_hit)
        begin
          rdata_out <= {29'h0, irq_mask};
        end
        for (int i = 0; i < TRUT_NUM_TIMERS; i++)
        begin
          if (trut_decode(req.addr, i) == TRUT_REG_START_COUNT)
          begin
            rdata_out <= count[i];
          end
          else if (trut_decode(req.addr, i) == TRUT_REG_CONTROL)
          begin
            rdata_out <= {31'h0, run_control_bit[i]};
          end
        end
      end
    end
  end

  // wrap pulse, registered
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wrap_out <= 3'h0;
    end
    else
    begin
      wrap_out <= wrap_evt;
    end
  end

  assign run_out = run_control_bit;
  assign irq_out = |(irq_status & irq_mask);
endmodule

// [verification/tb_three_rollover_up_timers.sv]
// tb_three_rollover_up_timers: self-checking bench
// assumes the register map of trut_pkg
`timescale 1ns/1ps
module tb_three_rollover_up_timers;
  import trut_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wr_in = 1'b0, rd_in = 1'b0, irq_out;
  logic [31:0] addr_in = '0, wdata_in = '0, rdata_out, d0, d1;
  logic [2:0] run_out, wrap_out, w0;
  int error_cnt = 0, cmp_count = 0;
  always #5 clk_in = ~clk_in;
  trut_timers uut (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .run_out, .wrap_out, .irq_out);
  task chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [31:0] a, d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // two back-to-back reads of one address
  task rd2(input logic [31:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    #1 d0 = rdata_out;
    w0 = wrap_out;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d1 = rdata_out;
  endtask
  task close_out();
    $display("cmp %0d err %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset values, last address unmapped
  task t_reset();
    for (int j = 0; j < 7; j++)
    begin
      rd2(TRUT_BASE_ADDR + 32'(4 * j));
      chk("reset", 32'h0, d0);
    end
  endtask
  task t_wrap(input int i);
    logic [31:0] b;
    b = TRUT_BASE_ADDR + 32'(8 * i);
    wr(b, 32'hFFFF_FFFE);
    wr(b + 32'h4, 32'h1);
    rd2(b);
    chk("count_top", 32'hFFFF_FFFF, d0);
    chk("count_zero", 32'h0, d1);
    chk("wrap_pulse", 32'h1 << i, {29'h0, w0});
    chk("run_on", 32'h1 << i, {29'h0, run_out});
    rd2(b + 32'h4);
    chk("ctrl_read", 32'h1, d0);
    rd2(TRUT_IRQ_STATUS_ADDR);
    chk("status", 32'h1 << i, d0);
    chk("irq_masked", 32'h0, {31'h0, irq_out});
    wr(TRUT_IRQ_MASK_ADDR, 32'h7);
    @(negedge clk_in);
    chk("irq_on", 32'h1, {31'h0, irq_out});
    wr(TRUT_IRQ_STATUS_ADDR, 32'h1 << i);
    wr(b + 32'h4, 32'h0);
    wr(b, 32'h1234_5678);
    rd2(b);
    chk("run_off", 32'h0, {29'h0, run_out});
    chk("irq_off", 32'h0, {31'h0, irq_out});
    chk("held", 32'h1234_5678, d1);
    wr(TRUT_IRQ_MASK_ADDR, 32'h0);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    for (int i = 0; i < 3; i++)
      t_wrap(i);
    close_out();
  end
  initial
  begin
    #50000;
    error_cnt++;
    close_out();
  end
endmodule

// [verification/trut_checker.sv]
// trut_checker: port checks for the timers
// assumes it is bound onto trut_timers
`timescale 1ns/1ps
module trut_checker
  import trut_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [2:0] run_out,
  input wire logic [2:0] wrap_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic rd0;
  assign rd0 = rd_in && !wr_in && addr_in == TRUT_BASE_ADDR;
  a_run_follows: assert property (wr_in && addr_in == TRUT_TIMER_ZERO_CONTROL_ADDR
    |=> run_out[0] == $past(wdata_in[0])) else $error("run bit");
  a_count_step: assert property (rd0 && run_out[0] ##1 rd0
    |=> rdata_out == $past(rdata_out) + 32'h1) else $error("count step");
  a_count_hold: assert property (rd0 && !run_out[0] ##1 rd0
    |=> rdata_out == $past(rdata_out)) else $error("count hold");
  a_wrap_run: assert property (wrap_out[0] |-> $past(run_out[0]))
    else $error("wrap while stopped");
  a_wrap_pulse: assert property (wrap_out[0] |=> !wrap_out[0])
    else $error("wrap pulse");
  a_irq_cause: assert property ($rose(irq_out)
    |-> wrap_out != 3'h0 || $past(wr_in && addr_in == TRUT_IRQ_MASK_ADDR))
    else $error("irq cause");
endmodule
bind trut_timers trut_checker chk_i (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .run_out, .wrap_out, .irq_out);
